// file: pta_pkg.sv
// =====================================================================
// Shared constants and types for the program memory table access path
package pta_pkg;
    // Address and data widths
    localparam int ADDR_W = 24;
    localparam int EA_W = 16;
    localparam int PAGE_W = 8;
    localparam int WORD_W = 24;
    localparam int LOW_W = 16;
    localparam int BYTE_W = 8;
    localparam int LANES = 3;
    // Erase page geometry: 1024 instructions, 3072 bytes
    localparam int PAGE_INSTR = 1024;
    localparam int PAGE_BYTES = 3072;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_LAST = 10'h3FF;
    // Modelled array: two erase pages of program words
    localparam int ARRAY_WORDS = 2048;
    localparam int IDX_W = 11;
    // Erased flash reads as all ones
    localparam logic [WORD_W-1:0] ERASE_VAL = 24'hFFFFFF;
    // Byte lane masks
    localparam logic [LANES-1:0] MASK_NONE = 3'h0;
    localparam logic [LANES-1:0] MASK_B0 = 3'h1;
    localparam logic [LANES-1:0] MASK_B1 = 3'h2;
    localparam logic [LANES-1:0] MASK_LOW = 3'h3;
    localparam logic [LANES-1:0] MASK_HIGH = 3'h4;
    localparam logic [LANES-1:0] MASK_ALL = 3'h7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [PAGE_W-1:0] PAGE_RST = 8'h00;

    // Table operations issued by the core
    typedef enum logic [2:0]
    {
        OP_READ_LOW,
        OP_READ_HIGH,
        OP_WRITE_LOW,
        OP_WRITE_HIGH,
        OP_ERASE_PAGE
    } pta_op_e;

    // Sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_ACCESS,
        ST_ERASE,
        ST_FINISH
    } pta_state_e;
endpackage

// file: pta_flash_if.sv
`timescale 1ns/1ns
// =====================================================================
// Word port between the access sequencer and the program array
interface pta_flash_if;
    import pta_pkg::*;
    logic [IDX_W-1:0] idx;
    logic [WORD_W-1:0] wdata;
    logic [LANES-1:0] mask;
    logic we;
    logic [WORD_W-1:0] rdata;

    modport ctrl
    (
        output idx,
        output wdata,
        output mask,
        output we,
        input rdata
    );
    modport mem
    (
        input idx,
        input wdata,
        input mask,
        input we,
        output rdata
    );
endinterface

// file: pta_flash_array.sv
`timescale 1ns/1ns
// =====================================================================
// Program word array with byte-lane writes and registered read
module pta_flash_array
    import pta_pkg::*;
(
    // Clock
    input wire logic clk,
    // Word port
    pta_flash_if.mem fa
);
    logic [WORD_W-1:0] mem_q [0:ARRAY_WORDS-1];
    logic [WORD_W-1:0] rdata_ff;

    // Per-lane write, one lane per byte of the 24-bit word
    // One process owns the array so it has a single driver
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (fa.we && fa.mask[i])
            begin
                mem_q[fa.idx][i*BYTE_W +: BYTE_W] <=
                    fa.wdata[i*BYTE_W +: BYTE_W];
            end
        end
    end

    // Registered read of the addressed word
    always_ff @(posedge clk)
    begin
        rdata_ff <= mem_q[fa.idx];
    end

    assign fa.rdata = rdata_ff;
endmodule

// file: pta_table_access.sv
`timescale 1ns/1ns
// =====================================================================
// Function
// - Target address is page register low byte above the 16-bit address.
// - Low reads and writes touch only word bits 15 to 0.
// - High reads and writes touch only word bits 23 to 16.
// - Low and high operations both offer word and byte width.
// - Self-programming erases whole pages of 1024 instructions, 3072 bytes.
// - Self-programming writes program memory one word at a time.
// - Flash reads, writes and erases work in normal operation, no mode.
// - Serial programmer and application both program through table path.
module pta_table_access
    import pta_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Table page register load
    input wire logic page_we,
    input wire logic [PAGE_W-1:0] page_wdata,
    // Table operation request
    input wire logic req_valid,
    input wire pta_op_e req_op,
    input wire logic req_byte,
    input wire logic req_ext,
    input wire logic [EA_W-1:0] req_ea,
    input wire logic [LOW_W-1:0] req_wdata,
    // Status and answer
    output logic [PAGE_W-1:0] page_q_ff,
    output logic [ADDR_W-1:0] prog_addr_ff,
    output logic [LOW_W-1:0] rd_data_ff,
    output logic busy_ff,
    output logic done_ff,
    output logic ext_active_ff
);
    pta_state_e state_ff;
    pta_op_e op_ff;
    logic byte_ff;
    logic [LOW_W-1:0] wdata_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic take;
    logic is_write;
    logic [LOW_W-1:0] nxt_rd_data;
    logic [WORD_W-1:0] acc_wdata;
    logic [LANES-1:0] acc_mask;

    pta_flash_if fa();

    pta_flash_array u_array
    (
        .clk(clk),
        .fa(fa.mem)
    );

    // =================================================================
    // Request acceptance
    // Accepted whenever idle; no special mode gates flash access
    assign take = req_valid && !busy_ff;
    assign is_write = (op_ff == OP_WRITE_LOW) || (op_ff == OP_WRITE_HIGH);

    // Table page register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            page_q_ff <= PAGE_RST;
        else if (page_we)
            page_q_ff <= page_wdata;
    end

    // Latch the operation and form the 24-bit program address
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_ff <= OP_READ_LOW;
            byte_ff <= 1'b0;
            wdata_ff <= 16'h0000;
            prog_addr_ff <= 24'h000000;
            ext_active_ff <= 1'b0;
        end
        else if (take)
        begin
            op_ff <= req_op;
            byte_ff <= req_byte;
            wdata_ff <= req_wdata;
            prog_addr_ff <= {page_q_ff, req_ea};
            ext_active_ff <= req_ext;
        end
    end

    // =================================================================
    // Sequencer: access, erase sweep, finish
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= ST_IDLE;
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (take && req_op == OP_ERASE_PAGE)
                        state_ff <= ST_ERASE;
                    else if (take)
                        state_ff <= ST_ACCESS;
                end
                ST_ACCESS:
                    state_ff <= ST_FINISH;
                ST_ERASE:
                begin
                    if (cnt_ff == CNT_LAST)
                        state_ff <= ST_FINISH;
                end
                ST_FINISH:
                    state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // Erase word counter walks all 1024 words of the page
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_ff <= CNT_ZERO;
        else if (state_ff == ST_ERASE)
            cnt_ff <= CNT_W'(cnt_ff + 10'h001);
        else
            cnt_ff <= CNT_ZERO;
    end

    // Busy and done flags
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            busy_ff <= take || (busy_ff && state_ff != ST_FINISH);
            done_ff <= (state_ff == ST_FINISH);
        end
    end

    // =================================================================
    // Byte lanes and write data for one program word
    always_comb
    begin
        acc_wdata = {wdata_ff[BYTE_W-1:0], wdata_ff};
        acc_mask = MASK_NONE;
        if (op_ff == OP_WRITE_LOW)
        begin
            if (!byte_ff)
                acc_mask = MASK_LOW;
            else if (prog_addr_ff[0])
                acc_mask = MASK_B1;
            else
                acc_mask = MASK_B0;
            // Byte mode repeats the byte on both low lanes
            acc_wdata = {wdata_ff[BYTE_W-1:0],
                byte_ff ? wdata_ff[BYTE_W-1:0] : wdata_ff[LOW_W-1:BYTE_W],
                wdata_ff[BYTE_W-1:0]};
        end
        else if (op_ff == OP_WRITE_HIGH)
        begin
            // Odd byte of the high half does not exist
            acc_mask = (byte_ff && prog_addr_ff[0]) ? MASK_NONE
                : MASK_HIGH;
        end
    end

    // Array port: one word per access, full page during erase
    assign fa.idx = (state_ff == ST_ERASE)
        ? {prog_addr_ff[IDX_W], cnt_ff} : prog_addr_ff[IDX_W:1];
    assign fa.we = (state_ff == ST_ACCESS && is_write)
        || (state_ff == ST_ERASE);
    assign fa.mask = (state_ff == ST_ERASE) ? MASK_ALL : acc_mask;
    assign fa.wdata = (state_ff == ST_ERASE) ? ERASE_VAL : acc_wdata;

    // =================================================================
    // Read formatting from the addressed half
    always_comb
    begin
        nxt_rd_data = 16'h0000;
        case (op_ff)
            OP_READ_LOW:
            begin
                if (!byte_ff)
                    nxt_rd_data = fa.rdata[LOW_W-1:0];
                else if (prog_addr_ff[0])
                    nxt_rd_data = {8'h00, fa.rdata[15:8]};
                else
                    nxt_rd_data = {8'h00, fa.rdata[7:0]};
            end
            OP_READ_HIGH:
            begin
                if (!(byte_ff && prog_addr_ff[0]))
                    nxt_rd_data = {8'h00, fa.rdata[23:16]};
            end
            default:
                nxt_rd_data = 16'h0000;
        endcase
    end

    // Read data register, loaded once the array word is out
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_ff <= 16'h0000;
        else if (state_ff == ST_FINISH &&
            (op_ff == OP_READ_LOW || op_ff == OP_READ_HIGH))
            rd_data_ff <= nxt_rd_data;
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_take_write;
        take && (req_op == OP_WRITE_LOW || req_op == OP_WRITE_HIGH);
    endsequence
    sequence s_write_pulse;
        fa.we ##1 !fa.we ##1 done_ff;
    endsequence
    sequence s_take_erase;
        take && req_op == OP_ERASE_PAGE;
    endsequence

    property p_addr_form;
        take |=> prog_addr_ff == {$past(page_q_ff), $past(req_ea)};
    endproperty
    a_addr_form: assert property (p_addr_form)
        else $error("program address not formed from page and address");

    property p_low_lanes;
        fa.we && state_ff == ST_ACCESS && op_ff == OP_WRITE_LOW
            |-> (fa.mask & MASK_HIGH) == MASK_NONE;
    endproperty
    a_low_lanes: assert property (p_low_lanes)
        else $error("low write touched the high byte");

    property p_high_lanes;
        fa.we && state_ff == ST_ACCESS && op_ff == OP_WRITE_HIGH
            |-> (fa.mask & MASK_LOW) == MASK_NONE;
    endproperty
    a_high_lanes: assert property (p_high_lanes)
        else $error("high write touched the low half");

    property p_word_width;
        fa.we && state_ff == ST_ACCESS && op_ff == OP_WRITE_LOW && !byte_ff
            |-> fa.mask == MASK_LOW && fa.wdata[15:0] == wdata_ff;
    endproperty
    a_word_width: assert property (p_word_width)
        else $error("low word write lost a byte");

    property p_byte_select;
        fa.we && state_ff == ST_ACCESS && op_ff == OP_WRITE_LOW && byte_ff
            |-> fa.mask == (prog_addr_ff[0] ? MASK_B1 : MASK_B0);
    endproperty
    a_byte_select: assert property (p_byte_select)
        else $error("byte lane does not follow address bit 0");

    property p_erase_start;
        s_take_erase |=> state_ff == ST_ERASE && cnt_ff == CNT_ZERO;
    endproperty
    a_erase_start: assert property (p_erase_start)
        else $error("erase did not start at the page base");

    property p_erase_len;
        $fell(state_ff == ST_ERASE) |-> $past(cnt_ff) == CNT_LAST
            && state_ff == ST_FINISH;
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase sweep not 1024 words long");

    property p_one_word;
        s_take_write |=> s_write_pulse;
    endproperty
    a_one_word: assert property (p_one_word)
        else $error("write was not a single word strobe");

    property p_no_mode;
        take && req_op != OP_ERASE_PAGE |-> ##3 done_ff;
    endproperty
    a_no_mode: assert property (p_no_mode)
        else $error("access did not finish in three cycles");

    property p_same_path;
        ext_active_ff && fa.we |-> busy_ff;
    endproperty
    a_same_path: assert property (p_same_path)
        else $error("programmer write outside the table sequence");
endmodule

// file: pta_core_model.sv
`timescale 1ns/1ns
// =====================================================================
// Core model: issues page loads and table operations
module pta_core_model
    import pta_pkg::*;
(
    // Clock and answer
    input wire logic clk,
    input wire logic done_ff,
    input wire logic [LOW_W-1:0] rd_data_ff,
    // Requests
    output logic page_we,
    output logic [PAGE_W-1:0] page_wdata,
    output logic req_valid,
    output pta_op_e req_op,
    output logic req_byte,
    output logic req_ext,
    output logic [EA_W-1:0] req_ea,
    output logic [LOW_W-1:0] req_wdata
);
    // Quiet levels at time zero
    initial
    begin
        page_we = 1'b0;
        page_wdata = 8'h00;
        req_valid = 1'b0;
        req_op = OP_READ_LOW;
        req_byte = 1'b0;
        req_ext = 1'b0;
        req_ea = 16'h0000;
        req_wdata = 16'h0000;
    end

    // Page register load, data scrambled once taken
    task automatic load_page(input logic [PAGE_W-1:0] pg);
    begin
        @(posedge clk);
        page_we <= 1'b1;
        page_wdata <= pg;
        @(posedge clk);
        page_we <= 1'b0;
        page_wdata <= ~pg;
    end
    endtask

    // One table operation; n counts cycles from take to done
    task automatic op(input pta_op_e o, input logic b, input logic x,
        input logic [EA_W-1:0] ea, input logic [LOW_W-1:0] wd,
        output logic [LOW_W-1:0] rd, output int n);
    begin
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= o;
        req_byte <= b;
        req_ext <= x;
        req_ea <= ea;
        req_wdata <= wd;
        @(posedge clk);
        req_valid <= 1'b0;
        req_ea <= ~ea;
        req_wdata <= ~wd;
        n = 1;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (done_ff !== 1'b1 && n < 1100);
        rd = rd_data_ff;
    end
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
// =====================================================================
// Self-checking bench for the table access path
module testbench
    import pta_pkg::*;
;
    logic clk, rst_n, page_we, req_valid, req_byte, req_ext;
    logic busy_ff, done_ff, ext_active_ff;
    logic [PAGE_W-1:0] page_wdata, page_q_ff;
    pta_op_e req_op;
    logic [EA_W-1:0] req_ea;
    logic [LOW_W-1:0] req_wdata, rd_data_ff;
    logic [ADDR_W-1:0] prog_addr_ff;
    int error_cnt, checks, cyc;

    pta_table_access uut (.clk(clk), .rst_n(rst_n), .page_we(page_we),
        .page_wdata(page_wdata), .req_valid(req_valid), .req_op(req_op),
        .req_byte(req_byte), .req_ext(req_ext), .req_ea(req_ea),
        .req_wdata(req_wdata), .page_q_ff(page_q_ff),
        .prog_addr_ff(prog_addr_ff), .rd_data_ff(rd_data_ff),
        .busy_ff(busy_ff), .done_ff(done_ff),
        .ext_active_ff(ext_active_ff));

    pta_core_model core (.clk(clk), .done_ff(done_ff),
        .rd_data_ff(rd_data_ff), .page_we(page_we),
        .page_wdata(page_wdata), .req_valid(req_valid), .req_op(req_op),
        .req_byte(req_byte), .req_ext(req_ext), .req_ea(req_ea),
        .req_wdata(req_wdata));

    // =================================================================
    // Clock, hang guard, report
    initial clk = 1'b0;
    always #50 clk = ~clk;

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test;
    begin
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask

    // Operation with expected cycle count and, for reads, data
    task automatic xf(input pta_op_e o, input logic b, input logic x,
        input logic [15:0] ea, input logic [15:0] wd, input int nc,
        input logic [15:0] exp);
        logic [15:0] rd;
        int n;
    begin
        core.op(o, b, x, ea, wd, rd, n);
        chk(24'(n), 24'(nc));
        if (o == OP_READ_LOW || o == OP_READ_HIGH)
            chk({8'h00, rd}, {8'h00, exp});
    end
    endtask

    // =================================================================
    // Scenarios
    task automatic t_page;
        logic [15:0] rd;
        int n;
    begin
        core.load_page(8'hA5);
        #1;
        chk({16'h0000, page_q_ff}, 24'h0000A5);
        fork
            core.op(OP_READ_LOW, 1'b0, 1'b0, 16'h1234, 16'h0000, rd, n);
            begin
                repeat (3) @(posedge clk);
                #1;
                chk({23'h0, busy_ff}, 24'h1);
            end
        join
        chk(prog_addr_ff, 24'hA51234);
        chk({23'h0, busy_ff}, 24'h0);
        core.load_page(8'h00);
    end
    endtask

    task automatic t_erase_write;
    begin
        xf(OP_ERASE_PAGE, 1'b0, 1'b0, 16'h0000, 16'h0, 1026, 16'h0);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h07FE, 16'h0, 3, 16'hFFFF);
        xf(OP_READ_HIGH, 1'b0, 1'b0, 16'h0000, 16'h0, 3, 16'h00FF);
        xf(OP_WRITE_LOW, 1'b0, 1'b0, 16'h0002, 16'hBEEF, 3, 16'h0);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'hBEEF);
        xf(OP_READ_HIGH, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'h00FF);
        xf(OP_WRITE_HIGH, 1'b0, 1'b0, 16'h0002, 16'hC334, 3, 16'h0);
        xf(OP_READ_HIGH, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'h0034);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'hBEEF);
    end
    endtask

    task automatic t_byte;
    begin
        xf(OP_WRITE_LOW, 1'b1, 1'b0, 16'h0003, 16'h115A, 3, 16'h0);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'h5AEF);
        xf(OP_READ_LOW, 1'b1, 1'b0, 16'h0002, 16'h0, 3, 16'h00EF);
        xf(OP_READ_LOW, 1'b1, 1'b0, 16'h0003, 16'h0, 3, 16'h005A);
        xf(OP_WRITE_HIGH, 1'b1, 1'b0, 16'h0002, 16'h9977, 3, 16'h0);
        xf(OP_WRITE_HIGH, 1'b1, 1'b0, 16'h0003, 16'h0011, 3, 16'h0);
        xf(OP_READ_HIGH, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'h0077);
        xf(OP_READ_HIGH, 1'b1, 1'b0, 16'h0003, 16'h0, 3, 16'h0000);
        xf(OP_READ_HIGH, 1'b1, 1'b0, 16'h0002, 16'h0, 3, 16'h0077);
    end
    endtask

    task automatic t_ext_page1;
    begin
        xf(OP_WRITE_LOW, 1'b0, 1'b1, 16'h0004, 16'h0F0F, 3, 16'h0);
        chk({23'h0, ext_active_ff}, 24'h1);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h0004, 16'h0, 3, 16'h0F0F);
        chk({23'h0, ext_active_ff}, 24'h0);
        xf(OP_ERASE_PAGE, 1'b0, 1'b1, 16'h0800, 16'h0, 1026, 16'h0);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h0FFE, 16'h0, 3, 16'hFFFF);
        xf(OP_READ_LOW, 1'b0, 1'b0, 16'h0002, 16'h0, 3, 16'h5AEF);
    end
    endtask

    // =================================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_page();
        t_erase_write();
        t_byte();
        t_ext_page1();
        finish_test();
    end
endmodule
